// file: logic/cdf_top.sv
// clock divider and fan-out: picks one of two input clocks, divides by two and four
// assumes clk at 200 MHz and input clocks at most half that rate, sampled as levels
// outputs are levels that move on clk rising edges, except that reset low drives them low at once
`timescale 1ns/10ps

// How it works
// [R1] select low uses differential pair, high single-ended
// [R2] reset low forces all outputs low immediately
// [R3] open differential pair reads true low, complement high
// [R4] divide by two and four, two plus six outputs
// [R5] half and quarter rising edges coincide from start
// [R6] reset release restarts both stages from cleared state
module cdf_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // input-source select
  input wire logic src_select,
  // single-ended input clock
  input wire logic single_ended_clock_in,
  // differential input clock and its open-pair detector
  input wire logic diff_clock_in_true,
  input wire logic diff_clock_in_comp,
  input wire logic diff_pair_open,
  // half-rate outputs
  output logic half_rate_out_a,
  output logic half_rate_out_b,
  // quarter-rate outputs
  output logic quarter_rate_out_a,
  output logic quarter_rate_out_b,
  output logic quarter_rate_out_c,
  output logic quarter_rate_out_d,
  output logic quarter_rate_out_e,
  output logic quarter_rate_out_f
);

  // receiver and source select
  logic diff_true_eff;
  logic diff_comp_eff;
  logic diff_level;
  logic src_level;

  // edge detector of the selected clock
  logic src_prev_reg;
  logic src_rise;

  // shared divider phase
  cdf_pkg::cdf_phase_t phase_reg;
  cdf_pkg::cdf_phase_t phase_next;

  // divided clock flip-flops and their next values
  logic half_reg;
  logic quarter_reg;
  logic half_next;
  logic quarter_next;

  // reset-gated fan-out, one bit per pin
  logic [cdf_pkg::HALF_COUNT-1:0] half_fan;
  logic [cdf_pkg::QUARTER_COUNT-1:0] quarter_fan;

  // differential receiver: high only while true stands above complement
  function automatic logic diff_receive(
    input logic true_lvl,
    input logic comp_lvl
  );
    diff_receive = true_lvl & ~comp_lvl;
  endfunction

  // source mux; the select is a plain level, not a clocked choice
  // so a change of select is seen by the edge detector like any input move
  function automatic logic pick_source(
    input logic sel,
    input logic diff_lvl,
    input logic single_lvl
  );
    if (sel == cdf_pkg::SEL_DIFF) begin
      pick_source = diff_lvl;
    end else begin
      pick_source = single_lvl;
    end
  endfunction

  // one step of the shared phase walk, taken on each rise of the selected clock
  function automatic cdf_pkg::cdf_phase_t phase_step(
    input cdf_pkg::cdf_phase_t ph
  );
    case (ph)
      // from the aligned start both stages rise together
      cdf_pkg::CDF_CLEARED: phase_step = cdf_pkg::CDF_PH_HH; // R5
      // half falls, quarter holds
      cdf_pkg::CDF_PH_HH: phase_step = cdf_pkg::CDF_PH_LH;
      // half rises again, quarter falls
      cdf_pkg::CDF_PH_LH: phase_step = cdf_pkg::CDF_PH_HL;
      // both low
      cdf_pkg::CDF_PH_HL: phase_step = cdf_pkg::CDF_PH_LL;
      // both rise together, so alignment holds every quarter period
      cdf_pkg::CDF_PH_LL: phase_step = cdf_pkg::CDF_PH_HH; // R4
      // an illegal code returns to the aligned start instead of locking up
      default: phase_step = cdf_pkg::CDF_CLEARED;
    endcase
  endfunction

  // half-rate level carried by a phase
  // the cleared phase reads low, so nothing moves before the first rise
  function automatic logic half_of(
    input cdf_pkg::cdf_phase_t ph
  );
    case (ph)
      cdf_pkg::CDF_CLEARED: half_of = cdf_pkg::OUT_RESET;
      cdf_pkg::CDF_PH_HH: half_of = 1'b1;
      cdf_pkg::CDF_PH_LH: half_of = 1'b0;
      cdf_pkg::CDF_PH_HL: half_of = 1'b1;
      cdf_pkg::CDF_PH_LL: half_of = 1'b0;
      default: half_of = cdf_pkg::OUT_RESET;
    endcase
  endfunction

  // quarter-rate level carried by a phase
  // high only in the two phases that follow a joint rise
  function automatic logic quarter_of(
    input cdf_pkg::cdf_phase_t ph
  );
    case (ph)
      cdf_pkg::CDF_CLEARED: quarter_of = cdf_pkg::OUT_RESET;
      cdf_pkg::CDF_PH_HH: quarter_of = 1'b1;
      cdf_pkg::CDF_PH_LH: quarter_of = 1'b1;
      cdf_pkg::CDF_PH_HL: quarter_of = 1'b0;
      cdf_pkg::CDF_PH_LL: quarter_of = 1'b0;
      default: quarter_of = cdf_pkg::OUT_RESET;
    endcase
  endfunction

  // reset gate for one pin; used by both families
  // a plain AND keeps the reset path free of any clocked element
  function automatic logic gate_pin(
    input logic level,
    input logic run_n
  );
    gate_pin = level & run_n;
  endfunction

  // an open pair is biased to a fixed state so the receiver never chatters
  assign diff_true_eff = diff_pair_open ? cdf_pkg::OPEN_TRUE_LEVEL : diff_clock_in_true; // R3
  assign diff_comp_eff = diff_pair_open ? cdf_pkg::OPEN_COMP_LEVEL : diff_clock_in_comp; // R3
  // receiver reads high only when true is above complement
  assign diff_level = diff_receive(diff_true_eff, diff_comp_eff);

  // source mux; a switch mid-cycle may add or drop one input edge
  assign src_level = pick_source(src_select, diff_level, single_ended_clock_in); // R1

  // previous level of the selected clock, for rising-edge detection
  // cleared in reset, so a clock already high at release counts as a rise
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      src_prev_reg <= cdf_pkg::SRC_PREV_RESET;
    end else begin
      src_prev_reg <= src_level;
    end
  end

  // a rise needs a low sample then a high one, so each level must last one clk
  assign src_rise = src_level & ~src_prev_reg;

  // one shared phase walk keeps both stages locked; a rise from cleared raises both
  // with no rise the phase simply holds
  always_comb begin
    phase_next = phase_reg;
    if (src_rise) begin
      phase_next = phase_step(phase_reg); // R4
    end
  end

  // output levels decoded from the next phase so they leave flip-flops
  // decoding the next phase saves a cycle of latency against the rise
  always_comb begin
    half_next = half_of(phase_next);
    quarter_next = quarter_of(phase_next);
  end

  // divider phase; reset returns it to the aligned cleared point
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase_reg <= cdf_pkg::CDF_CLEARED; // R6
    end else begin
      phase_reg <= phase_next;
    end
  end

  // divided clock flip-flops; both load on the same edge, so they cannot drift
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      half_reg <= cdf_pkg::OUT_RESET; // R6
      quarter_reg <= cdf_pkg::OUT_RESET;
    end else begin
      half_reg <= half_next; // R4
      quarter_reg <= quarter_next; // R4
    end
  end

  // fan-out; reset gates outputs at once since the flops only clear on an edge
  // the gate adds one AND to every pin alike, so it costs no skew between them
  genvar gi;
  generate
    for (gi = 0; gi < cdf_pkg::HALF_COUNT; gi = gi + 1) begin : g_half
      assign half_fan[gi] = gate_pin(half_reg, rst_n); // R2
    end
    for (gi = 0; gi < cdf_pkg::QUARTER_COUNT; gi = gi + 1) begin : g_quarter
      assign quarter_fan[gi] = gate_pin(quarter_reg, rst_n); // R2
    end
  endgenerate

  // half-rate pins
  assign half_rate_out_a = half_fan[0];
  assign half_rate_out_b = half_fan[1];

  // quarter-rate pins
  assign quarter_rate_out_a = quarter_fan[0];
  assign quarter_rate_out_b = quarter_fan[1];
  assign quarter_rate_out_c = quarter_fan[2];
  assign quarter_rate_out_d = quarter_fan[3];
  assign quarter_rate_out_e = quarter_fan[4];
  assign quarter_rate_out_f = quarter_fan[5];

endmodule // cdf_top

// file: logic/cdf_pkg.sv
// constants for the clock divider and fan-out block
// assumes one system clock; the input clocks arrive as sampled levels
package cdf_pkg;
  // input-source select encoding
  localparam logic SEL_DIFF = 1'b0;
  localparam logic SEL_SINGLE = 1'b1;
  // forced levels for an open differential pair
  localparam logic OPEN_TRUE_LEVEL = 1'b0;
  localparam logic OPEN_COMP_LEVEL = 1'b1;
  // level of every divided output in reset
  localparam logic OUT_RESET = 1'b0;
  // reset value of the input edge detector
  localparam logic SRC_PREV_RESET = 1'b0;
  // fan-out counts per output family
  localparam int HALF_COUNT = 2;
  localparam int QUARTER_COUNT = 6;
  // divider phase, one-hot; CLEARED is the aligned start point
  typedef enum logic [4:0] {
    CDF_CLEARED = 5'h01,
    CDF_PH_HH   = 5'h02,
    CDF_PH_LH   = 5'h04,
    CDF_PH_HL   = 5'h08,
    CDF_PH_LL   = 5'h10
  } cdf_phase_t;
endpackage

// file: sim/cdf_sva.sv
// checker of the divided outputs of cdf_top
// assumes it is bound into cdf_top and sees only its ports
`timescale 1ns/10ps
module cdf_sva (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // sources
  input wire logic src_select,
  input wire logic single_ended_clock_in,
  input wire logic diff_clock_in_true,
  input wire logic diff_clock_in_comp,
  input wire logic diff_pair_open,
  // watched outputs
  input wire logic half_rate_out_a,
  input wire logic half_rate_out_b,
  input wire logic quarter_rate_out_a,
  input wire logic quarter_rate_out_f
);
  logic prev_reg;
  wire h = half_rate_out_a;
  wire q = quarter_rate_out_a;
  // selected level; an open pair reads low
  wire lvl = src_select ? single_ended_clock_in
    : diff_clock_in_true & ~diff_clock_in_comp & ~diff_pair_open;
  // cleared in reset so a level already high counts as a rise at release
  always_ff @(posedge clk) prev_reg <= rst_n & lvl;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_rise;
    lvl && !prev_reg;
  endsequence
  AST_RST: assert property (disable iff (1'b0) !rst_n |-> !(h | q))
    else $error("output high in reset");
  AST_FAN: assert property (h == half_rate_out_b && q == quarter_rate_out_f)
    else $error("fan-out copies differ");
  AST_TOG: assert property (s_rise |=> h != $past(h))
    else $error("half rate missed a rise");
  AST_HOLD: assert property (!(lvl && !prev_reg) |=> $stable(h) && $stable(q))
    else $error("output moved without a rise");
  AST_QTR: assert property (s_rise |=> (q != $past(q)) == h)
    else $error("quarter not aligned to half");
  AST_OPEN: assert property (!src_select && diff_pair_open |=> $stable(h))
    else $error("open pair moved output");
  AST_START: assert property ($rose(rst_n) |-> !h && !q)
    else $error("no cleared start");
endmodule // cdf_sva
bind cdf_top cdf_sva chk_i (
  .clk(clk),
  .rst_n(rst_n),
  .src_select(src_select),
  .single_ended_clock_in(single_ended_clock_in),
  .diff_clock_in_true(diff_clock_in_true),
  .diff_clock_in_comp(diff_clock_in_comp),
  .diff_pair_open(diff_pair_open),
  .half_rate_out_a(half_rate_out_a),
  .half_rate_out_b(half_rate_out_b),
  .quarter_rate_out_a(quarter_rate_out_a),
  .quarter_rate_out_f(quarter_rate_out_f)
);

// file: sim/cdf_proc_model.sv
// processor clock load: counts rising edges of two divided clocks
// assumes the clocks are levels sampled on clk
`timescale 1ns/10ps
module cdf_proc_model (
  // sampling clock and clock inputs
  input wire logic clk,
  input wire logic half_clk,
  input wire logic quarter_clk,
  // rises seen so far
  output int n_half,
  output int n_quarter
);
  logic hp = 1'h0, qp = 1'h0;
  int cnt_h = 0, cnt_q = 0;
  assign n_half = cnt_h;
  assign n_quarter = cnt_q;
  // a rise is a low sample followed by a high one
  always @(posedge clk) begin
    cnt_h <= cnt_h + int'(half_clk && !hp);
    cnt_q <= cnt_q + int'(quarter_clk && !qp);
    {hp, qp} <= {half_clk, quarter_clk};
  end
endmodule // cdf_proc_model

// file: sim/cdf_top_tb.sv
// bench for cdf_top: toggles the input clocks and checks all outputs
// assumes cdf_sva is bound in and cdf_proc_model is the load
`timescale 1ns/10ps
module cdf_top_tb;
  logic clk = 1'h0, rst_n = 1'h0, src_select = 1'h1, single_ended_clock_in = 1'h0;
  logic diff_clock_in_true = 1'h0, diff_clock_in_comp = 1'h1, diff_pair_open = 1'h0;
  logic half_rate_out_a, half_rate_out_b, quarter_rate_out_a, quarter_rate_out_b;
  logic quarter_rate_out_c, quarter_rate_out_d, quarter_rate_out_e, quarter_rate_out_f;
  int n_mismatch = 0, n_compared = 0, k = 0, cyc = 0, nh, nq;
  wire logic [7:0] outs = {half_rate_out_a, half_rate_out_b, quarter_rate_out_a,
    quarter_rate_out_b, quarter_rate_out_c, quarter_rate_out_d, quarter_rate_out_e,
    quarter_rate_out_f};
  always #2.5 clk = ~clk;
  cdf_top uut (
    .clk(clk),
    .rst_n(rst_n),
    .src_select(src_select),
    .single_ended_clock_in(single_ended_clock_in),
    .diff_clock_in_true(diff_clock_in_true),
    .diff_clock_in_comp(diff_clock_in_comp),
    .diff_pair_open(diff_pair_open),
    .half_rate_out_a(half_rate_out_a),
    .half_rate_out_b(half_rate_out_b),
    .quarter_rate_out_a(quarter_rate_out_a),
    .quarter_rate_out_b(quarter_rate_out_b),
    .quarter_rate_out_c(quarter_rate_out_c),
    .quarter_rate_out_d(quarter_rate_out_d),
    .quarter_rate_out_e(quarter_rate_out_e),
    .quarter_rate_out_f(quarter_rate_out_f)
  );
  cdf_proc_model load (.clk(clk), .half_clk(half_rate_out_b), .quarter_clk(quarter_rate_out_f),
    .n_half(nh), .n_quarter(nq));
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
    end
  endtask
  // after r rises: half = r odd, quarter high for r mod 4 in 1..2
  function logic [7:0] want(input int r);
    int t;
    t = r + 1;
    want = {{2{r[0]}}, {6{t[1]}}};
  endfunction
  // one full period on a source, s high = single-ended; m = rises expected
  task pulse(input bit s, input int m);
    repeat (2) begin
      @(negedge clk);
      if (s) single_ended_clock_in ^= 1'h1;
      else {diff_clock_in_true, diff_clock_in_comp} ^= 2'h3;
    end
    k += m;
    chk(outs, want(k));
  endtask
  task t_single;
    repeat (8) pulse(1, 1);
    repeat (2) pulse(0, 0);
  endtask
  task t_diff;
    src_select = 1'h0;
    repeat (3) pulse(0, 1);
    pulse(1, 0);
    diff_pair_open = 1'h1;
    pulse(0, 0);
    diff_pair_open = 1'h0;
  endtask
  task t_reset;
    @(negedge clk) rst_n = 1'h0;
    #1 chk(outs, 8'h00);
    k = 0;
    repeat (2) @(negedge clk);
    rst_n = 1'h1;
    repeat (2) pulse(0, 1);
  endtask
  task results;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // run is about 50 cycles; a hang ends here
  always @(posedge clk) if (++cyc == 500) begin
    n_mismatch++;
    results();
  end
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'h1;
    t_single();
    t_diff();
    t_reset();
    @(negedge clk) chk({nh[3:0], nq[3:0]}, 8'h74);
    results();
  end
endmodule // cdf_top_tb
